/* common/pbs_regs.svh */
/*
 Timing and field constants for the pipelined burst memory link.
 Assumes inclusion by bare name from package, interface and modules.
*/
`ifndef PBS_REGS_SVH
`define PBS_REGS_SVH
`define PBS_ADDR_W 20
`define PBS_DATA_W 32
`define PBS_BYTES 4
`define PBS_BURST_W 2
`define PBS_BURST_ONE 2'h1
`define PBS_BURST_ZERO 2'h0
`define PBS_SLEEP_CYCLES 2'h2
`endif

/* common/pbs_pkg.sv */
/*
 Types for the pipelined burst memory link; only the device end uses them.
 Assumes pbs_regs.svh is on the include path.
*/
`default_nettype none
`include "pbs_regs.svh"
package pbs_pkg;
    typedef enum logic [3:0] {
        PBS_CMD_IDLE  = 4'h1,
        PBS_CMD_READ  = 4'h2,
        PBS_CMD_WRITE = 4'h4,
        PBS_CMD_DESEL = 4'h8
    } pbs_cmd_t;
    typedef enum logic [2:0] {
        PBS_PH_DESEL = 3'h1,
        PBS_PH_READ  = 3'h2,
        PBS_PH_WRITE = 3'h4
    } pbs_phase_t;
endpackage
`default_nettype wire

/* common/pbs_if.sv */
/*
 Pin-level link between memory controller and burst memory device.
 Data pins are split into out, enable (low drives) and resolved level.
*/
`default_nettype none
`include "pbs_regs.svh"
interface pbs_if;
    logic [`PBS_ADDR_W-1:0] addr;
    logic clk_qualify_n;
    logic chip_sel_one_n;
    logic chip_sel_two;
    logic chip_sel_three_n;
    logic advance_or_load_n;
    logic write_en_n;
    logic [`PBS_BYTES-1:0] byte_write_sel_n;
    logic out_en_n;
    logic sleep_request;
    logic burst_order;
    logic [`PBS_DATA_W-1:0] dq_dev_out;
    logic dq_dev_oe_n;
    logic [`PBS_DATA_W-1:0] dq_ctl_out;
    logic dq_ctl_oe_n;
    logic [`PBS_DATA_W-1:0] dq;
    modport device (
        input addr, clk_qualify_n, chip_sel_one_n, chip_sel_two, chip_sel_three_n,
        input advance_or_load_n, write_en_n, byte_write_sel_n, out_en_n,
        input sleep_request, burst_order, dq,
        output dq_dev_out, dq_dev_oe_n
    );
    modport ctrl (
        output addr, clk_qualify_n, chip_sel_one_n, chip_sel_two, chip_sel_three_n,
        output advance_or_load_n, write_en_n, byte_write_sel_n, out_en_n,
        output sleep_request, burst_order, dq_ctl_out, dq_ctl_oe_n,
        input dq
    );
endinterface
`default_nettype wire

/* hdl/pbs_burst_step.sv */
/*
 Burst address sequencer: next two low address bits for one step.
 Assumes the caller holds the start bits and step count.
*/
`default_nettype none
`include "pbs_regs.svh"
module pbs_burst_step (
    input wire logic [`PBS_BURST_W-1:0] i_start,
    input wire logic [`PBS_BURST_W-1:0] i_step,
    input wire logic i_interleave,
    output logic [`PBS_BURST_W-1:0] o_low
);
    // Only the two low bits move; the add wraps by width
    always_comb begin
        if (i_interleave) begin
            o_low = i_start ^ i_step;                                // [RULE18] [RULE13]
        end else begin
            o_low = i_start + i_step;                                // [RULE19] [RULE14]
        end
    end
endmodule
`default_nettype wire

/* hdl/pbs_device.sv */
/*
 Device end: registered pipelined burst memory with clock qualify,
 pipelined deselect, burst counter, output-enable masking and sleep.
 Assumes the controller keeps its side of the link; strap is static.
*/
//
// Behaviour
// [RULE1] Inputs and read data registered on rise
// [RULE2] Clock qualify high freezes all state; the sleep counter and the strap latch still update
// [RULE3] All selects and load capture address
// [RULE4] Write enable picks direction; byte selects mask
// [RULE5] Reads, writes, deselects share pipeline offset
// [RULE6] Controller loads fresh address after deselect
// [RULE7] Read needs qualify, selects, write high, load
// [RULE8] Read data appears one cycle after load
// [RULE9] Output enable low required to drive data
// [RULE10] Back-to-back commands with no idle cycle
// [RULE11] Deselect floats outputs after next rise
// [RULE12] Burst counter gives four addresses
// [RULE13] Strap low linear, high interleaved order
// [RULE14] Counter uses two low bits, wraps
// [RULE15] Advance ignores selects and write enable
// [RULE16] Direction latched only at burst load
// [RULE17] Sleep high idles, keeps data, defaults low
// [RULE18] Interleaved: start xor step count
// [RULE19] Linear: start plus step modulo four
// [RULE20] Outputs float on write, emerge, deselect
// [RULE21] Floating strap means interleaved, static
// [RULE22] Load clears step count to zero
`default_nettype none
`include "pbs_regs.svh"
module pbs_device #(
    parameter int DEPTH_W = 6
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    pbs_if.device link
);
    localparam int DEPTH = 1 << DEPTH_W;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        pbs_pkg::pbs_phase_t phase;
        logic [`PBS_ADDR_W-1:0] base;
        logic [`PBS_BURST_W-1:0] step;
        logic was_desel;
        logic wr_pend;
        logic [`PBS_ADDR_W-1:0] wr_addr;
        logic [`PBS_BYTES-1:0] wr_mask_n;
        logic [`PBS_DATA_W-1:0] rd_data;
        logic drive_n;
        logic [1:0] sleep_cnt;
        logic order;
        logic order_taken;
    } pbs_dev_st_t;

    pbs_dev_st_t st_ff;
    pbs_dev_st_t nxt_st;
    logic [`PBS_DATA_W-1:0] mem [DEPTH];
    logic [`PBS_BURST_W-1:0] low_bits;
    logic [`PBS_ADDR_W-1:0] cur_addr;
    logic sel_all;
    logic asleep;

    function automatic logic [`PBS_DATA_W-1:0] pbs_mask(input logic [`PBS_BYTES-1:0] m_n,
            input logic [`PBS_DATA_W-1:0] nw, input logic [`PBS_DATA_W-1:0] old);
        logic [`PBS_DATA_W-1:0] r;
        r = old;
        for (int b = 0; b < `PBS_BYTES; b++) begin
            if (!m_n[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    pbs_burst_step u_step (
        .i_start(st_ff.base[`PBS_BURST_W-1:0]),
        .i_step(st_ff.step),
        .i_interleave(st_ff.order),
        .o_low(low_bits)
    );

    assign sel_all = !link.chip_sel_one_n && link.chip_sel_two && !link.chip_sel_three_n;
    assign asleep = (st_ff.sleep_cnt == `PBS_SLEEP_CYCLES);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        cur_addr = {st_ff.base[`PBS_ADDR_W-1:`PBS_BURST_W], low_bits};
        if (!st_ff.order_taken) begin
            nxt_st.order = link.burst_order;                         // [RULE21]
            nxt_st.order_taken = 1'b1;
        end
        if (link.sleep_request) begin
            if (!asleep) begin
                nxt_st.sleep_cnt = st_ff.sleep_cnt + 2'h1;           // [RULE17]
            end
        end else begin
            nxt_st.sleep_cnt = 2'h0;
        end
        if (!link.clk_qualify_n && !link.sleep_request && !asleep) begin  // [RULE2]
            nxt_st.wr_pend = 1'b0;
            nxt_st.drive_n = 1'b1;
            if (!link.advance_or_load_n) begin
                nxt_st.was_desel = (st_ff.phase == pbs_pkg::PBS_PH_DESEL);
                if (sel_all) begin
                    nxt_st.base = link.addr;                         // [RULE3]
                    nxt_st.step = `PBS_BURST_ZERO;                   // [RULE22]
                    nxt_st.phase = link.write_en_n ? pbs_pkg::PBS_PH_READ
                                                   : pbs_pkg::PBS_PH_WRITE; // [RULE4] [RULE16] [RULE7]
                end else begin
                    nxt_st.phase = pbs_pkg::PBS_PH_DESEL;            // [RULE11]
                end
            end else begin
                nxt_st.was_desel = 1'b0;
                nxt_st.step = st_ff.step + `PBS_BURST_ONE;           // [RULE15] [RULE12] [RULE14]
                nxt_st.base = st_ff.base;
            end
            // Issue edge effect seen one qualified cycle later
            cur_addr = {nxt_st.base[`PBS_ADDR_W-1:`PBS_BURST_W],
                        (link.advance_or_load_n ? (st_ff.order ?
                            (st_ff.base[`PBS_BURST_W-1:0] ^ nxt_st.step) :
                            (st_ff.base[`PBS_BURST_W-1:0] + nxt_st.step))
                         : link.addr[`PBS_BURST_W-1:0])};
            if (nxt_st.phase == pbs_pkg::PBS_PH_READ) begin
                nxt_st.rd_data = mem[cur_addr[DEPTH_W-1:0]];         // [RULE8] [RULE5]
                nxt_st.drive_n = nxt_st.was_desel;                   // [RULE20]
            end else if (nxt_st.phase == pbs_pkg::PBS_PH_WRITE) begin
                nxt_st.wr_pend = 1'b1;                               // [RULE10]
                nxt_st.wr_addr = cur_addr;
                nxt_st.wr_mask_n = link.byte_write_sel_n;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n) begin        // [RULE1]
        if (!i_reset_n) begin
            st_ff <= '{phase: pbs_pkg::PBS_PH_DESEL, drive_n: 1'b1, order: 1'b1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Write data phase: data taken one qualified edge after issue
    always_ff @(posedge i_clock) begin
        if (!link.clk_qualify_n && st_ff.wr_pend) begin
            mem[st_ff.wr_addr[DEPTH_W-1:0]] <=
                pbs_mask(st_ff.wr_mask_n, link.dq, mem[st_ff.wr_addr[DEPTH_W-1:0]]); // [RULE4]
        end
    end

    // Output enable is asynchronous and gates the registered drive
    assign link.dq_dev_out = st_ff.rd_data;
    assign link.dq_dev_oe_n = st_ff.drive_n | link.out_en_n;         // [RULE9] [RULE20]
endmodule
`default_nettype wire

/* hdl/pbs_ctrl.sv */
/*
 Controller end: turns user read/write/burst requests into link cycles.
 Assumes the device answers with one cycle of read latency.
*/
`default_nettype none
`include "pbs_regs.svh"
module pbs_ctrl (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic i_advance,
    input wire logic [`PBS_ADDR_W-1:0] i_addr,
    input wire logic [`PBS_DATA_W-1:0] i_wdata,
    input wire logic [`PBS_BYTES-1:0] i_byte_n,
    input wire logic i_hold,
    input wire logic i_sleep,
    input wire logic i_interleave,
    output logic o_rvalid,
    output logic [`PBS_DATA_W-1:0] o_rdata,
    pbs_if.ctrl link
);
    typedef struct packed {
        logic [`PBS_ADDR_W-1:0] addr;
        logic qual_n;
        logic sel;
        logic adv;
        logic we_n;
        logic [`PBS_BYTES-1:0] bw_n;
        logic sleep;
        logic rd_p1;
        logic rd_p2;
        logic wr_p1;
        logic dir_wr;
        logic [`PBS_DATA_W-1:0] wdata_p1;
        logic [`PBS_DATA_W-1:0] wdata;
        logic wdrive;
        logic rvalid;
        logic [`PBS_DATA_W-1:0] rdata;
    } pbs_ctl_st_t;

    pbs_ctl_st_t st_ff;
    pbs_ctl_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.qual_n = i_hold;
        nxt_st.sleep = i_sleep;                                      // [RULE17]
        nxt_st.rvalid = st_ff.rd_p2;                                 // [RULE8]
        nxt_st.rdata = link.dq;
        nxt_st.rd_p2 = 1'b0;
        if (!st_ff.qual_n) begin
            // Device takes the link command at this edge
            nxt_st.wdrive = st_ff.wr_p1;
            nxt_st.wdata = st_ff.wdata_p1;
            nxt_st.rd_p2 = st_ff.rd_p1;
            nxt_st.rd_p1 = 1'b0;
            nxt_st.wr_p1 = 1'b0;
        end
        if (!i_hold) begin
            nxt_st.adv = i_req && i_advance && st_ff.sel;            // [RULE6]
            nxt_st.sel = i_req && !i_sleep;
            nxt_st.we_n = !i_write;                                  // [RULE7]
            nxt_st.addr = i_addr;
            nxt_st.bw_n = i_byte_n;
            nxt_st.wdata_p1 = i_wdata;
            if (!nxt_st.adv) begin
                nxt_st.dir_wr = nxt_st.sel && i_write;
            end
            nxt_st.rd_p1 = nxt_st.sel && !nxt_st.dir_wr;
            nxt_st.wr_p1 = nxt_st.sel && nxt_st.dir_wr;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_ff <= '{we_n: 1'b1, bw_n: '1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.addr = st_ff.addr;
    assign link.clk_qualify_n = st_ff.qual_n;
    assign link.chip_sel_one_n = !st_ff.sel;
    assign link.chip_sel_two = st_ff.sel;
    assign link.chip_sel_three_n = !st_ff.sel;
    assign link.advance_or_load_n = st_ff.adv;
    assign link.write_en_n = st_ff.we_n;
    assign link.byte_write_sel_n = st_ff.bw_n;
    assign link.out_en_n = 1'b0;                                     // [RULE9]
    assign link.sleep_request = st_ff.sleep;
    assign link.burst_order = i_interleave;
    assign link.dq_ctl_out = st_ff.wdata;
    assign link.dq_ctl_oe_n = !st_ff.wdrive;
    assign o_rvalid = st_ff.rvalid;
    assign o_rdata = st_ff.rdata;
endmodule
`default_nettype wire

/* verif/pbs_link_props.sv */
/*
 Checker for the pins between controller end and device end.
 Assumes the bench instantiates it beside the interface, by name.
*/
`default_nettype none
`include "pbs_regs.svh"
module pbs_link_props (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic clk_qualify_n,
    input wire logic chip_sel_one_n,
    input wire logic chip_sel_two,
    input wire logic chip_sel_three_n,
    input wire logic advance_or_load_n,
    input wire logic write_en_n,
    input wire logic out_en_n,
    input wire logic sleep_request,
    input wire logic [`PBS_DATA_W-1:0] dq_dev_out,
    input wire logic dq_dev_oe_n,
    input wire logic dq_ctl_oe_n
);
    // ----
    // Last qualified command was a deselect
    // ----
    logic qual;
    logic sel;
    logic desel_ff;
    assign qual = !clk_qualify_n && !sleep_request;
    assign sel = !chip_sel_one_n && chip_sel_two && !chip_sel_three_n;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            desel_ff <= 1'b1;
        end else if (qual && !advance_or_load_n) begin
            desel_ff <= !sel;
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    sequence s_load(we_n);
        qual && sel && !advance_or_load_n && write_en_n == we_n;
    endsequence
    sequence s_step;
        qual && advance_or_load_n;
    endsequence
    AST_READ_DRIVES: assert property (
        s_load(1'b1) ##0 !desel_ff
        |=> out_en_n || !dq_dev_oe_n) else $error("read data not driven");
    AST_DESEL_FLOATS: assert property (
        qual && !sel && !advance_or_load_n ##1 qual |=> dq_dev_oe_n)
        else $error("deselect left outputs driven");
    AST_WRITE_FLOATS: assert property (s_load(1'b0) |=> dq_dev_oe_n)
        else $error("outputs driven in write data phase");
    AST_WRITE_BURST_DIR: assert property (
        s_load(1'b0) ##1 s_step |=> dq_dev_oe_n) else $error("burst changed direction");
    AST_READ_BURST: assert property (
        s_load(1'b1) ##0 !desel_ff ##1 s_step
        |=> out_en_n || !dq_dev_oe_n) else $error("read burst beat not driven");
    AST_OE_MASKS: assert property (out_en_n |-> dq_dev_oe_n)
        else $error("driving with output enable high");
    AST_FREEZE: assert property (clk_qualify_n |=> $stable(dq_dev_out))
        else $error("output changed while unqualified");
    AST_NO_FIGHT: assert property (dq_dev_oe_n || dq_ctl_oe_n)
        else $error("both ends drive data");
    AST_RELOAD: assert property (desel_ff && qual && sel |-> !advance_or_load_n)
        else $error("no address load after deselect");
endmodule
`default_nettype wire

/* verif/pbs_test.sv */
/*
 Self-checking bench: controller end and device end joined by the link.
 Assumes design files and the checker are compiled before it.
*/
`default_nettype none
`include "pbs_regs.svh"
module pbs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic req = 0, wr = 0, adv = 0, hold = 0, slp = 0, ilv = 0, dir = 0, dp = 0, dprev = 0, qn = 0;
    logic [`PBS_ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0, scr = '0, mem [64];
    logic [31:0] q [$];
    logic [3:0] byte_n = 4'hf;
    logic [5:0] base = '0;
    logic [1:0] step = '0;
    logic rvalid;
    logic [31:0] rdata;
    integer seed = 32'h201ec5df;
    int n_mismatch = 0;
    int n_compared = 0;
    pbs_if lnk();
    assign lnk.dq = !lnk.dq_dev_oe_n ? lnk.dq_dev_out : !lnk.dq_ctl_oe_n ? lnk.dq_ctl_out : scr;
    pbs_device #(.DEPTH_W(6)) i_pbs_device (.i_clock(i_clock), .i_reset_n(i_reset_n), .link(lnk));
    pbs_ctrl i_pbs_ctrl (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_req(req), .i_write(wr),
        .i_advance(adv), .i_addr(addr), .i_wdata(wdata), .i_byte_n(byte_n), .i_hold(hold),
        .i_sleep(slp), .i_interleave(ilv), .o_rvalid(rvalid), .o_rdata(rdata), .link(lnk));
    pbs_link_props i_pbs_link_props (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .clk_qualify_n(lnk.clk_qualify_n), .chip_sel_one_n(lnk.chip_sel_one_n),
        .chip_sel_two(lnk.chip_sel_two), .chip_sel_three_n(lnk.chip_sel_three_n),
        .advance_or_load_n(lnk.advance_or_load_n), .write_en_n(lnk.write_en_n),
        .out_en_n(lnk.out_en_n), .sleep_request(lnk.sleep_request), .dq_dev_out(lnk.dq_dev_out),
        .dq_dev_oe_n(lnk.dq_dev_oe_n), .dq_ctl_oe_n(lnk.dq_ctl_oe_n));
    always #4 i_clock = ~i_clock;
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] rnd();
        return $random(seed);
    endfunction
    function automatic logic [5:0] baddr(input logic [5:0] b, input logic [1:0] k);
        return {b[5:2], ilv ? b[1:0] ^ k : b[1:0] + k};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmd(input int k, input logic w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] bn);
        @(posedge i_clock);
        wdata <= d;
        if (k == 1) begin
            base = a;
            step = 2'h0;
            dir = w;
        end
        if (k == 2) step = step + 2'h1;
        req <= k == 1 || k == 2;
        adv <= k == 2;
        hold <= k == 3;
        wr <= w;
        addr <= {14'h0, a};
        byte_n <= bn;
        if (k == 1 || k == 2) begin
            if (dir) begin
                for (int i = 0; i < 4; i++) if (!bn[i]) mem[baddr(base, step)][8*i +: 8] = d[8*i +: 8];
            end else q.push_back(mem[baddr(base, step)]);
        end
    endtask
    task automatic burst(input logic w, input logic hi);
        cmd(1, w, {hi, 5'(rnd())}, rnd(), 4'(rnd()));
        repeat (rnd() % 4) cmd(2, 1'(rnd()), 6'h0, rnd(), 4'(rnd()));
    endtask
    task automatic rounds(input int nw, input int nr);
        repeat (nw) burst(1'b1, 1'b0);
        burst(1'b0, 1'b1);
        repeat (nr) begin
            if (rnd() % 4 == 0) begin
                cmd(3, 1'b0, 6'h0, 32'h0, 4'hf);
                burst(1'b1, 1'b0);
                burst(1'b0, 1'b1);
            end else burst(1'b0, 1'(rnd()));
        end
    endtask
    // ----
    // Monitor and main sequence
    // ----
    always @(posedge i_clock) begin
        dp = !lnk.clk_qualify_n && !lnk.advance_or_load_n
            && !(!lnk.chip_sel_one_n && lnk.chip_sel_two && !lnk.chip_sel_three_n);
        qn = !lnk.clk_qualify_n;
        scr <= scr * 32'h5 + 32'h3;
        if (rvalid === 1'b1) begin
            if (q.size() == 0) check(32'h1, 32'h0);
            else check(rdata, q.pop_front());
        end
        #1;
        if (dprev && qn && i_reset_n) check(32'(lnk.dq_dev_oe_n), 32'h1);
        dprev = dp;
    end
    initial begin
        repeat (100000) @(posedge i_clock);
        n_mismatch++;
        test_done();
    end
    initial begin
        for (int o = 0; o < 2; o++) begin
            ilv <= o[0];
            i_reset_n <= 1'b0;
            repeat (20) @(posedge i_clock);
            i_reset_n <= 1'b1;
            for (int a = 0; a < 64; a++) cmd(1, 1'b1, 6'(a), rnd(), 4'h0);
            rounds(20, 30);
            repeat (3) cmd(0, 1'b0, 6'h0, 32'h0, 4'hf);
            slp <= 1'b1;
            repeat (4) @(posedge i_clock);
            slp <= 1'b0;
            repeat (3) cmd(0, 1'b0, 6'h0, 32'h0, 4'hf);
            rounds(5, 10);
            for (int i = 0; i < 20 && q.size() != 0; i++) cmd(0, 1'b0, 6'h0, 32'h0, 4'hf);
            check(32'(q.size()), 32'h0);
            if (q.size() != 0) test_done();
            $display("test order %0d done", o);
        end
        test_done();
    end
endmodule
`default_nettype wire
